// File: hw/sau_core.sv
// UART core reached over an SPI slave port, with baud generator.
// Assumes SCK, SCS_N, SDI and RX come from outside the CLK domain.
// Operation
// - TX driven only when module_on and transmit_on, else floated.
// - RX used only when module_on and receive_on, else ignored.
// - Holding byte moves to tx_shifter, sent LSB first per baud period.
// - RX shifted in LSB first, then moved to the holding register.
// - Shifters are never reachable by commands.
// - One shared data register serves transmit and receive.
// - Command: bit4 register/FIFO, bit3 write/read, bits2-0 address.
// - Map: status, control A, control B, baud, control C.
// - Status flags are read only; writes there change nothing.
// - Parity fault set on bad parity, only with parity enabled.
// - Noise flag set with rx_full_flag, not on an overrun.
// - Framing fault set for a missing stop bit of current byte.
// - Status read then data access clears the error flags.
// - Status resets to 0x0b.
// - Transaction is 16 bits under chip select; early rise discards.
// - Writes execute after 16 bits and chip select high.
// - SDI latched on SCK rise, SDO changed on SCK fall.
// - Overrun set on overflow, blocks loading of received bytes until cleared; transmit goes on.
`timescale 1ns/1ps
`include "sau_params.svh"
module sau_core
  import sau_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SCS_N,
  input wire logic SCK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE_N,
  output logic TX,
  output logic TX_OE_N,
  input wire logic RX
);
  logic scs_n_s;
  logic sck_s;
  logic sdi_s;
  logic rx_s;
  sau_sync #(.INIT(1'b1)) u_scs (.clk(CLK), .resetn(RESETN),
    .din(SCS_N), .dout(scs_n_s));
  sau_sync #(.INIT(1'b0)) u_sck (.clk(CLK), .resetn(RESETN),
    .din(SCK), .dout(sck_s));
  sau_sync #(.INIT(1'b0)) u_sdi (.clk(CLK), .resetn(RESETN),
    .din(SDI), .dout(sdi_s));
  sau_sync #(.INIT(1'b1)) u_rx (.clk(CLK), .resetn(RESETN),
    .din(RX), .dout(rx_s));

  // Registers and SPI state
  logic sck_prev_q, scs_prev_q;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] shin_q, shin_d;
  logic [7:0] shout_q, shout_d;
  logic sdo_q, sdo_d, sdo_oe_n_q, sdo_oe_n_d;
  logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
  logic [7:0] ctrl_c_q, ctrl_c_d, baud_q, baud_d;
  logic [7:0] data_q, data_d;
  logic parity_fault_q, parity_fault_d, nf_q, nf_d, framing_fault_q, framing_fault_d, overrun_fault_q, overrun_fault_d;
  logic rx_full_flag_q, rx_full_flag_d, tx_empty_flag_q, tx_empty_flag_d;
  logic stat_rd_q, stat_rd_d;
  logic sck_rise, sck_fall, cs_rise;
  logic [7:0] cmd;
  logic data_access, data_write;
  logic [7:0] status;
  logic rx_load, rx_parity_fault, rx_framing_fault, rx_noise, tx_take;
  logic rx_quiet, tx_quiet;
  logic module_on, tx_on, rx_on, soft_rst;

  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign cs_rise = scs_n_s && !scs_prev_q;
  assign cmd = shin_q[15:8];
  assign module_on = ctrl_a_q[`SAU_A_MODULE_ON];
  assign tx_on = module_on && ctrl_b_q[`SAU_B_TRANSMIT_ON];
  assign rx_on = module_on && ctrl_b_q[`SAU_B_RECEIVE_ON];
  assign soft_rst = ctrl_c_q[`SAU_C_SOFT_RESET];
  assign status = {parity_fault_q, nf_q, framing_fault_q, overrun_fault_q,
                   rx_quiet, rx_full_flag_q, tx_quiet, tx_empty_flag_q};

  function automatic logic [7:0] rd_mux(input logic [7:0] c);
    rd_mux = 8'h00;
    if (!c[`SAU_CMD_REG_BIT])
      rd_mux = data_q;
    else
      case (c[2:0])
        `SAU_ADDR_STATUS: rd_mux = status;
        `SAU_ADDR_CTRL_A: rd_mux = ctrl_a_q;
        `SAU_ADDR_CTRL_B: rd_mux = ctrl_b_q;
        `SAU_ADDR_BAUD: rd_mux = baud_q;
        `SAU_ADDR_CTRL_C: rd_mux = ctrl_c_q;
        default: rd_mux = 8'h00;
      endcase
  endfunction

  // Shared baud tick, sixteen samples per bit
  logic [7:0] bdiv_q, bdiv_d;
  logic tick;
  assign tick = (bdiv_q == 8'h00);
  always_comb
  begin
    bdiv_d = tick ? baud_q : bdiv_q - 8'h01;
  end

  // Transmitter
  sau_tx_state_t txs_q, txs_d;
  logic [3:0] tph_q, tph_d;
  logic [3:0] tbit_q, tbit_d;
  logic [8:0] tsh_q, tsh_d;
  logic tx_q, tx_d;
  logic [3:0] tx_bits;
  assign tx_bits = ctrl_a_q[`SAU_A_NINE_BIT] ? 4'd9 : 4'd8;
  assign tx_quiet = (txs_q == SAU_TX_IDLE) && tx_empty_flag_q;
  assign tx_take = (txs_q == SAU_TX_IDLE) && !tx_empty_flag_q && tx_on;
  always_comb
  begin
    txs_d = txs_q;
    tph_d = tph_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    tx_d = tx_q;
    case (txs_q)
      SAU_TX_IDLE:
      begin
        tx_d = !ctrl_a_q[`SAU_A_SEND_BREAK];
        if (tx_take)
        begin
          tsh_d = {ctrl_a_q[`SAU_A_TX_NINTH], data_q};
          txs_d = SAU_TX_START;
          tph_d = 4'd0;
        end
      end
      SAU_TX_START, SAU_TX_DATA, SAU_TX_STOP:
      begin
        if (tick)
        begin
          tph_d = tph_q + 4'd1;
          if (txs_q == SAU_TX_START)
            tx_d = 1'b0;
          else if (txs_q == SAU_TX_DATA)
            tx_d = tsh_q[0];
          else
            tx_d = 1'b1;
          if (tph_q == `SAU_OVERSAMPLE)
          begin
            tph_d = 4'd0;
            if (txs_q == SAU_TX_START)
            begin
              txs_d = SAU_TX_DATA;
              tbit_d = 4'd0;
            end
            else if (txs_q == SAU_TX_DATA)
            begin
              tsh_d = {1'b0, tsh_q[8:1]};
              tbit_d = tbit_q + 4'd1;
              if (tbit_q == tx_bits - 4'd1)
                txs_d = SAU_TX_STOP;
            end
            else
              txs_d = SAU_TX_IDLE;
          end
        end
      end
      default: txs_d = SAU_TX_IDLE;
    endcase
    if (!tx_on)
    begin
      txs_d = SAU_TX_IDLE;
      tx_d = 1'b1;
    end
  end

  // Receiver
  sau_rx_state_t rxs_q, rxs_d;
  logic [3:0] rph_q, rph_d;
  logic [3:0] rbit_q, rbit_d;
  logic [8:0] rsh_q, rsh_d;
  logic [2:0] smp_q, smp_d;
  logic noise_q, noise_d;
  logic rx_in, maj;
  assign rx_in = rx_on ? rx_s : 1'b1;
  assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2])
             | (smp_q[1] & smp_q[2]);
  assign rx_quiet = (rxs_q == SAU_RX_IDLE);
  always_comb
  begin
    rxs_d = rxs_q;
    rph_d = rph_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    smp_d = smp_q;
    noise_d = noise_q;
    rx_load = 1'b0;
    rx_parity_fault = 1'b0;
    rx_framing_fault = 1'b0;
    rx_noise = noise_q;
    case (rxs_q)
      SAU_RX_IDLE:
        if (!rx_in)
        begin
          rxs_d = SAU_RX_START;
          rph_d = 4'd0;
          noise_d = 1'b0;
        end
      SAU_RX_START, SAU_RX_DATA, SAU_RX_STOP:
        if (tick)
        begin
          rph_d = rph_q + 4'd1;
          if (rph_q >= 4'd7 && rph_q <= 4'd9)
            smp_d = {smp_q[1:0], rx_in};
          if (rph_q == `SAU_OVERSAMPLE)
          begin
            rph_d = 4'd0;
            if (!(&smp_q) && (|smp_q))
              noise_d = 1'b1;
            rx_noise = noise_d;
            if (rxs_q == SAU_RX_START)
            begin
              rxs_d = maj ? SAU_RX_IDLE : SAU_RX_DATA;
              rbit_d = 4'd0;
            end
            else if (rxs_q == SAU_RX_DATA)
            begin
              rsh_d = tx_bits == 4'd9 ? {maj, rsh_q[8:1]}
                                      : {1'b0, maj, rsh_q[7:1]};
              rbit_d = rbit_q + 4'd1;
              if (rbit_q == tx_bits - 4'd1)
                rxs_d = SAU_RX_STOP;
            end
            else
            begin
              rxs_d = SAU_RX_IDLE;
              rx_load = 1'b1;
              rx_framing_fault = !maj;
              rx_parity_fault = ctrl_a_q[`SAU_A_PARITY_ON] &&
                ((^rsh_q) ^ ctrl_a_q[`SAU_A_PARITY_SENSE]);
            end
          end
        end
      default: rxs_d = SAU_RX_IDLE;
    endcase
    if (!rx_on)
      rxs_d = SAU_RX_IDLE;
  end

  // SPI slave and register file
  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    shin_d = shin_q;
    shout_d = shout_q;
    sdo_d = sdo_q;
    sdo_oe_n_d = scs_n_s;
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    baud_d = baud_q;
    data_d = data_q;
    parity_fault_d = parity_fault_q;
    nf_d = nf_q;
    framing_fault_d = framing_fault_q;
    overrun_fault_d = overrun_fault_q;
    rx_full_flag_d = rx_full_flag_q;
    tx_empty_flag_d = tx_empty_flag_q;
    stat_rd_d = stat_rd_q;
    data_access = 1'b0;
    data_write = 1'b0;
    if (scs_n_s)
      bit_cnt_d = 5'd0;
    else
    begin
      if (sck_rise && bit_cnt_q != `SAU_SPI_BITS)
      begin
        shin_d = {shin_q[14:0], sdi_s};
        bit_cnt_d = bit_cnt_q + 5'd1;
        if (bit_cnt_q == 5'd7)
        begin
          shout_d = rd_mux({shin_q[6:0], sdi_s});
          // Command bits 7..1 sit in shin_q[6:0], bit 0 on sdi_s
          if (shin_q[6:4] == 3'h0 && !shin_q[`SAU_CMD_REG_BIT-1]
              && !shin_q[`SAU_CMD_WR_BIT-1])
            data_access = 1'b1;
          else if (shin_q[6:0] == 7'h08 && !sdi_s)
            stat_rd_d = 1'b1;
        end
      end
      if (sck_fall && bit_cnt_q >= 5'd8 && bit_cnt_q < `SAU_SPI_BITS)
      begin
        sdo_d = shout_q[7];
        shout_d = {shout_q[6:0], 1'b0};
      end
    end
    // Write command once 16 bits done and chip select returns
    if (cs_rise && bit_cnt_q == `SAU_SPI_BITS && cmd[`SAU_CMD_WR_BIT]
        && cmd[7:5] == 3'h0)
    begin
      if (!cmd[`SAU_CMD_REG_BIT])
      begin
        data_d = shin_q[7:0];
        tx_empty_flag_d = 1'b0;
        data_write = 1'b1;
      end
      else
        case (cmd[2:0])
          `SAU_ADDR_CTRL_A: ctrl_a_d = shin_q[7:0];
          `SAU_ADDR_CTRL_B: ctrl_b_d = shin_q[7:0];
          `SAU_ADDR_BAUD: baud_d = shin_q[7:0];
          `SAU_ADDR_CTRL_C: ctrl_c_d = shin_q[7:0];
          default: ;
        endcase
    end
    if ((data_access || data_write) && stat_rd_q)
    begin
      parity_fault_d = 1'b0;
      nf_d = 1'b0;
      framing_fault_d = 1'b0;
      overrun_fault_d = 1'b0;
      rx_full_flag_d = 1'b0;
      stat_rd_d = 1'b0;
    end
    if (tx_take)
      tx_empty_flag_d = 1'b1;
    if (rx_load)
    begin
      if (rx_full_flag_q || overrun_fault_q)
        overrun_fault_d = 1'b1;
      else
      begin
        data_d = rsh_q[7:0];
        ctrl_a_d[`SAU_A_RX_NINTH] = rsh_q[8];
        rx_full_flag_d = 1'b1;
        nf_d = nf_q | rx_noise;
        framing_fault_d = rx_framing_fault;
        parity_fault_d = parity_fault_q | rx_parity_fault;
      end
    end
    if (soft_rst)
    begin
      ctrl_c_d = `SAU_CTRL_C_RESET;
      {parity_fault_d, nf_d, framing_fault_d, overrun_fault_d, rx_full_flag_d} = 5'h00;
      tx_empty_flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sck_prev_q <= 1'b0;
      scs_prev_q <= 1'b1;
      bit_cnt_q <= 5'd0;
      shin_q <= 16'h0000;
      shout_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
      ctrl_a_q <= `SAU_CTRL_A_RESET;
      ctrl_b_q <= `SAU_CTRL_B_RESET;
      ctrl_c_q <= `SAU_CTRL_C_RESET;
      baud_q <= `SAU_BAUD_RESET;
      data_q <= 8'h00;
      {parity_fault_q, nf_q, framing_fault_q, overrun_fault_q} <= 4'h0;
      rx_full_flag_q <= 1'b0;
      tx_empty_flag_q <= 1'b1;
      stat_rd_q <= 1'b0;
      bdiv_q <= 8'h00;
      txs_q <= SAU_TX_IDLE;
      tph_q <= 4'd0;
      tbit_q <= 4'd0;
      tsh_q <= 9'h000;
      tx_q <= 1'b1;
      rxs_q <= SAU_RX_IDLE;
      rph_q <= 4'd0;
      rbit_q <= 4'd0;
      rsh_q <= 9'h000;
      smp_q <= 3'h7;
      noise_q <= 1'b0;
      TX_OE_N <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_s;
      scs_prev_q <= scs_n_s;
      bit_cnt_q <= bit_cnt_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      sdo_q <= sdo_d;
      sdo_oe_n_q <= sdo_oe_n_d;
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
      baud_q <= baud_d;
      data_q <= data_d;
      parity_fault_q <= parity_fault_d;
      nf_q <= nf_d;
      framing_fault_q <= framing_fault_d;
      overrun_fault_q <= overrun_fault_d;
      rx_full_flag_q <= rx_full_flag_d;
      tx_empty_flag_q <= tx_empty_flag_d;
      stat_rd_q <= stat_rd_d;
      bdiv_q <= bdiv_d;
      txs_q <= txs_d;
      tph_q <= tph_d;
      tbit_q <= tbit_d;
      tsh_q <= tsh_d;
      tx_q <= tx_d;
      rxs_q <= rxs_d;
      rph_q <= rph_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      smp_q <= smp_d;
      noise_q <= noise_d;
      TX_OE_N <= !tx_on;
    end
  end
  assign SDO = sdo_q;
  assign SDO_OE_N = sdo_oe_n_q;
  assign TX = tx_q;
endmodule // sau_core

// File: hw/sau_params.svh
// Constants for the SPI attached UART core: offsets, fields, resets, timing.
// Assumes inclusion from sau_core by bare name; the package does not include it.
`ifndef SAU_PARAMS_SVH
`define SAU_PARAMS_SVH
`define SAU_ADDR_STATUS 3'h0
`define SAU_ADDR_CTRL_A 3'h1
`define SAU_ADDR_CTRL_B 3'h2
`define SAU_ADDR_BAUD 3'h3
`define SAU_ADDR_CTRL_C 3'h4
`define SAU_CMD_REG_BIT 4
`define SAU_CMD_WR_BIT 3
`define SAU_STATUS_RESET 8'h0b
`define SAU_CTRL_A_RESET 8'h00
`define SAU_CTRL_B_RESET 8'h00
`define SAU_CTRL_C_RESET 8'h00
`define SAU_BAUD_RESET 8'h00
`define SAU_A_MODULE_ON 7
`define SAU_A_NINE_BIT 6
`define SAU_A_PARITY_ON 5
`define SAU_A_PARITY_SENSE 4
`define SAU_A_STOP_LEN 3
`define SAU_A_SEND_BREAK 2
`define SAU_A_RX_NINTH 1
`define SAU_A_TX_NINTH 0
`define SAU_B_TRANSMIT_ON 7
`define SAU_B_RECEIVE_ON 6
`define SAU_C_SOFT_RESET 7
`define SAU_SPI_BITS 5'd16
`define SAU_OVERSAMPLE 4'd15
`endif

// File: hw/sau_pkg.sv
// Types shared by the SPI attached UART core.
// Assumes sau_params.svh is on the include path.
package sau_pkg;
  typedef enum logic [1:0] {
    SAU_TX_IDLE = 2'b00,
    SAU_TX_START = 2'b01,
    SAU_TX_DATA = 2'b10,
    SAU_TX_STOP = 2'b11
  } sau_tx_state_t;
  typedef enum logic [1:0] {
    SAU_RX_IDLE = 2'b00,
    SAU_RX_START = 2'b01,
    SAU_RX_DATA = 2'b10,
    SAU_RX_STOP = 2'b11
  } sau_rx_state_t;
endpackage

// File: hw/sau_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes one clock; output changes when stages two and three agree.
`timescale 1ns/1ps
module sau_sync
  import sau_pkg::*;
#(
  parameter logic INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  logic out_d;
  always_comb
  begin
    out_d = out_q;
    if (s2_q == s3_q)
    begin
      out_d = s3_q;
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end
  assign dout = out_q;
endmodule // sau_sync

// File: test/sau_core_sva.sv
// Port checker for sau_core.
// Assumes each SCK level lasts at least 8 CLK cycles.
`timescale 1ns/1ps
module sau_core_chk
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SCS_N,
  input wire logic SCK,
  input wire logic SDO,
  input wire logic SDO_OE_N,
  input wire logic TX,
  input wire logic TX_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_reset_idle;
    !$past(RESETN) |-> TX && TX_OE_N && SDO_OE_N;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_tx_on_after_cs;
    $fell(TX_OE_N) |-> SCS_N && $past(SCS_N, 2);
  endproperty
  a_tx_on_after_cs: assert property (p_tx_on_after_cs)
    else $error("transmit enabled inside a transaction");
  property p_sdo_release;
    SCS_N [*8] |-> SDO_OE_N;
  endproperty
  a_sdo_release: assert property (p_sdo_release)
    else $error("SDO driven while deselected");
  property p_sdo_drive;
    !SCS_N [*8] |-> !SDO_OE_N;
  endproperty
  a_sdo_drive: assert property (p_sdo_drive)
    else $error("SDO not driven while selected");
  property p_sdo_cause;
    $fell(SDO_OE_N) |-> !SCS_N && !$past(SCS_N, 2);
  endproperty
  a_sdo_cause: assert property (p_sdo_cause)
    else $error("SDO enabled without chip select");
  property p_sdo_on_fall;
    !SDO_OE_N && $changed(SDO) |-> !SCK && !$past(SCK, 2);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall)
    else $error("SDO changed outside SCK low phase");
  property p_tx_idle_off;
    TX_OE_N |-> TX;
  endproperty
  a_tx_idle_off: assert property (p_tx_idle_off)
    else $error("TX not idle while disabled");
  property p_start_len;
    $fell(TX) |-> !TX [*8];
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start bit too short");
endmodule // sau_core_chk

bind sau_core sau_core_chk chk (.CLK(CLK), .RESETN(RESETN),
  .SCS_N(SCS_N), .SCK(SCK), .SDO(SDO), .SDO_OE_N(SDO_OE_N),
  .TX(TX), .TX_OE_N(TX_OE_N));

// File: test/sau_peer.sv
// Serial device on the UART pins: captures TX bytes, sends RX frames.
// Assumes bit_cyc equals 16 x (baud divisor + 1) CLK cycles.
`timescale 1ns/1ps
module sau_peer
(
  input wire logic CLK,
  input wire logic TX,
  input wire logic TX_OE_N,
  output logic RX
);
  logic line;
  logic [7:0] last_byte;
  int byte_cnt = 0;
  int bit_cyc = 16;
  // Floating pin reads as pulled high
  assign line = TX_OE_N ? 1'b1 : TX;
  initial RX = 1'b1;
  always
  begin
    @(negedge line);
    repeat (bit_cyc / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_cyc) @(posedge CLK);
      last_byte[i] = line;
    end
    repeat (bit_cyc) @(posedge CLK);
    byte_cnt++;
  end
  // Eight or nine data bits; glitch flips mid data bit 0 for 2 cycles
  // Glitch wants bit_cyc 32, so only one of the three samples sees it
  task automatic send(input logic [8:0] b, input int nb, input logic stop,
    input logic glitch);
    logic [10:0] f;
    f = {stop, b, 1'b0};
    if (nb == 8)
      f[9] = stop;
    for (int i = 0; i < nb + 2; i++)
    begin
      @(posedge CLK) RX <= f[i];
      repeat (bit_cyc / 2 - 1) @(posedge CLK);
      if (i == 1 && glitch)
      begin
        @(posedge CLK) RX <= ~f[i];
        @(posedge CLK);
        @(posedge CLK) RX <= f[i];
        repeat (bit_cyc / 2 - 3) @(posedge CLK);
      end
      else
        repeat (bit_cyc / 2) @(posedge CLK);
    end
    @(posedge CLK) RX <= 1'b1;
    repeat (bit_cyc) @(posedge CLK);
  endtask
endmodule // sau_peer

// File: test/spi_attached_uart_core_bench.sv
// Self-checking bench for sau_core over its SPI command port.
// Assumes sau_peer on the UART pins and the bound port checker.
`timescale 1ns/1ps
module spi_attached_uart_core_bench;
  logic clk = 0, resetn = 0, scs_n = 1, sck = 0, sdi = 0;
  logic sdo, sdo_oe_n, tx, tx_oe_n, rx;
  logic [7:0] rd;
  int error_cnt = 0, total_checks = 0;
  always #20 clk = ~clk;
  sau_core uut (.CLK(clk), .RESETN(resetn), .SCS_N(scs_n), .SCK(sck),
    .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n), .TX(tx),
    .TX_OE_N(tx_oe_n), .RX(rx));
  sau_peer peer (.CLK(clk), .TX(tx), .TX_OE_N(tx_oe_n), .RX(rx));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Fewer than 16 bits aborts the transaction
  task automatic spi(input logic [7:0] cmd, wdat, input int nbits);
    logic [15:0] word;
    word = {cmd, wdat};
    @(posedge clk) scs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge clk) sdi <= word[15 - i];
      tick(7);
      @(posedge clk) sck <= 1'b1;
      // Undriven SDO reads as the inverse
      rd = {rd[6:0], sdo_oe_n ? ~sdo : sdo};
      tick(7);
      @(posedge clk) sck <= 1'b0;
    end
    tick(8);
    @(posedge clk) scs_n <= 1'b1;
    tick(16);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    spi({5'h03, a}, d, 16);
  endtask
  task automatic reg_is(input string n, input logic [2:0] a,
    input logic [7:0] exp, mask);
    spi({5'h02, a}, 8'h00, 16);
    check(n, rd & mask, exp);
  endtask
  task automatic wait_peer(input int n);
    int k;
    k = 0;
    while (peer.byte_cnt < n && k < 3000)
    begin
      k++;
      tick(1);
    end
    if (k == 3000)
    begin
      check("peer_wait", 8'h01, 8'h00);
      print_verdict();
    end
  endtask
  initial
  begin
    tick(5);
    @(posedge clk) resetn <= 1'b1;
    tick(8);
    reg_is("status", 3'h0, 8'h0b, 8'hff);
    reg_is("ctrl_b", 3'h2, 8'h00, 8'hff);
    reg_is("ctrl_c", 3'h4, 8'h00, 8'hff);
    for (int a = 5; a < 8; a++)
    begin
      wr(a[2:0], 8'hff);
      reg_is("reserved", a[2:0], 8'h00, 8'hff);
    end
    wr(3'h0, 8'hf4);
    reg_is("status_ro", 3'h0, 8'h0b, 8'hff);
    wr(3'h2, 8'h3c);
    reg_is("ctrl_b", 3'h2, 8'h3c, 8'hff);
    spi(8'h1a, 8'h55, 12);
    reg_is("ctrl_b_abort", 3'h2, 8'h3c, 8'hff);
    spi(8'h9a, 8'h55, 16);
    reg_is("ctrl_b_badcmd", 3'h2, 8'h3c, 8'hff);
    wr(3'h3, 8'h00);
    reg_is("baud", 3'h3, 8'h00, 8'hff);
    wr(3'h1, 8'h80);
    check("tx_oe_off", {7'h00, tx_oe_n}, 8'h01);
    wr(3'h2, 8'hc0);
    check("tx_oe_on", {7'h00, tx_oe_n}, 8'h00);
    spi(8'h08, 8'ha5, 16);
    wait_peer(1);
    check("tx_byte", peer.last_byte, 8'ha5);
    spi(8'h0f, 8'h5a, 16);
    wait_peer(2);
    check("tx_byte_x", peer.last_byte, 8'h5a);
    peer.send(9'h03c, 8, 1'b1, 1'b0);
    reg_is("rx_full", 3'h0, 8'h0c, 8'hfc);
    spi(8'h00, 8'h00, 16);
    check("rx_byte", rd, 8'h3c);
    reg_is("rx_clear", 3'h0, 8'h08, 8'hfc);
    peer.send(9'h081, 8, 1'b0, 1'b0);
    reg_is("framing", 3'h0, 8'h2c, 8'hfc);
    spi(8'h00, 8'h00, 16);
    check("rx_byte_fe", rd, 8'h81);
    reg_is("fe_clear", 3'h0, 8'h08, 8'hfc);
    peer.send(9'h011, 8, 1'b1, 1'b0);
    peer.send(9'h022, 8, 1'b1, 1'b0);
    reg_is("overrun", 3'h0, 8'h1c, 8'hfc);
    spi(8'h00, 8'h00, 16);
    check("rx_kept", rd, 8'h11);
    reg_is("or_clear", 3'h0, 8'h08, 8'hfc);
    wr(3'h3, 8'h01);
    peer.bit_cyc = 32;
    peer.send(9'h0a5, 8, 1'b1, 1'b1);
    reg_is("noise", 3'h0, 8'h4c, 8'hfc);
    spi(8'h00, 8'h00, 16);
    check("rx_noisy", rd, 8'ha5);
    wr(3'h1, 8'he0);
    peer.send(9'h101, 9, 1'b1, 1'b0);
    reg_is("par_ok", 3'h0, 8'h0c, 8'hfc);
    reg_is("rx_ninth", 3'h1, 8'he2, 8'hff);
    spi(8'h00, 8'h00, 16);
    check("rx_9bit", rd, 8'h01);
    peer.send(9'h001, 9, 1'b1, 1'b0);
    reg_is("parity", 3'h0, 8'h8c, 8'hfc);
    wr(3'h4, 8'h80);
    reg_is("soft_rst", 3'h0, 8'h0b, 8'hff);
    reg_is("ctrl_c_self", 3'h4, 8'h00, 8'hff);
    print_verdict();
  end
endmodule // spi_attached_uart_core_bench
